// ### core/panel_output_sync_timing.sv
// Flat panel output sync timing: line sync rebuild, frame marker and shift clock.
//
// Decided for this implementation: strobed register access.
`timescale 1ns/1ps
`default_nettype none

// Summary of operation
// - Bypass set ignores edge fields, retrace control and output polarity overrides.
// - Source select clear passes line sync; set rebuilds it from input.
// - Leading and trailing edge fields apply only with source select set.
// - Both edge delays count pixel clocks from input line sync leading edge.
// - Leading code zero gives no delay; codes one to seven give two to eight.
// - Trailing code is its own delay; code zero gives no pulse.
// - Trailing edge at or before leading edge gives no pulse.
// - Output line polarity bit acts only with its override enable set.
// - Bypass set forwards the input frame sync unchanged.
// - Bypass clear generates the frame marker internally, per panel mode.
// - Single scan: one marker per incoming frame sync.
// - Dual scan: marker on first line and again after half the lines.
// - Frame marker inversion acts only with its override enable set.
// - Shift clock derives from the pixel clock by panel type ratio.
// - Ratios: quarter, 3-2-3 pattern, full, or half by panel type.
// - Retrace control gates shift clock to active data; no effect in STN.
// - Frame input polarity bit: clear pulses high, set pulses low.
// - Line input polarity normalises the input before edges are measured.
module panel_output_sync_timing #(
   parameter int TOTAL_W = panel_timing_pkg::ONE_TOTAL_W
) (
   // Pixel clock and reset
   input wire logic clk,
   input wire logic nrst,
   // Register port
   input wire logic [11:0] regAddr,
   input wire logic [31:0] regWrData,
   input wire logic regWrite,
   input wire logic regRead,
   output logic [31:0] regRdData,
   // Video source pins
   input wire logic inputLineSync,
   input wire logic inputFrameSync,
   input wire logic dataActive,
   // Panel pins
   output logic latchPulseOutput,
   output logic firstLineMarker,
   output logic panelShiftClock
);

   typedef struct packed {
      logic [31:0] timingOne;
      logic [31:0] timingTwo;
      logic [31:0] rdData;
      logic [1:0] lineSync;
      logic [1:0] frameSync;
      logic [1:0] actSync;
      logic linePrev;
      logic framePrev;
      logic [4:0] edgeCnt;
      logic running;
      logic lineOut;
      logic armed;
      logic marker;
      logic markerOut;
      logic [TOTAL_W-1:0] lineCount;
   } state_t;

   state_t st_r;
   state_t st_nxt;

   // Decoded controls.
   logic bypass;
   logic regen;
   logic lineInv;
   logic frameInv;
   logic [2:0] leadCode;
   logic [4:0] trailCode;
   logic [4:0] leadDly;
   logic [3:0] panelType;
   logic dual;
   logic [TOTAL_W-1:0] halfTotal;
   logic lineNorm;
   logic frameNorm;
   logic lineEdge;
   logic frameEdge;
   logic [4:0] pos;
   logic genActive;
   logic gateOpen;

   always_comb begin
      bypass = st_r.timingTwo[panel_timing_pkg::TWO_BYPASS];
      // Rebuilding needs source select, and bypass overrides it.
      regen = st_r.timingOne[panel_timing_pkg::ONE_SRC_SEL] && !bypass;
      // Output polarity only moves under its own enable, never in bypass.
      lineInv = !bypass && st_r.timingTwo[panel_timing_pkg::TWO_LINE_OVR] &&
                st_r.timingTwo[panel_timing_pkg::TWO_LINE_POL];
      frameInv = !bypass && st_r.timingTwo[panel_timing_pkg::TWO_FRAME_OVR] &&
                 st_r.timingTwo[panel_timing_pkg::TWO_FRAME_INV];
      leadCode = st_r.timingOne[panel_timing_pkg::ONE_LEAD_LSB +: panel_timing_pkg::ONE_LEAD_W];
      trailCode = st_r.timingOne[panel_timing_pkg::ONE_TRAIL_LSB +:
                                 panel_timing_pkg::ONE_TRAIL_W];
      leadDly = panel_timing_pkg::lead_delay(leadCode);
      panelType = st_r.timingTwo[panel_timing_pkg::TWO_TYPE_LSB +: panel_timing_pkg::TWO_TYPE_W];
      dual = panel_timing_pkg::is_dual(panelType);
      halfTotal = st_r.timingOne[panel_timing_pkg::ONE_TOTAL_LSB +: TOTAL_W] >> 1;
      // Inputs are normalised to pulse high before any edge is taken.
      lineNorm = st_r.lineSync[1] ^ st_r.timingOne[panel_timing_pkg::ONE_LINE_POL];
      frameNorm = st_r.frameSync[1] ^ st_r.timingOne[panel_timing_pkg::ONE_FRAME_POL];
      lineEdge = lineNorm && !st_r.linePrev;
      frameEdge = frameNorm && !st_r.framePrev;
      // Position zero is the cycle in which the leading edge is seen.
      pos = lineEdge ? 5'h00 : st_r.edgeCnt;
      // A trailing edge at or before the leading one leaves no pulse.
      genActive = (lineEdge || st_r.running) && (pos >= leadDly) && (pos < trailCode);
      // Retrace gating is honoured only outside bypass and outside STN.
      gateOpen = bypass || !st_r.timingTwo[panel_timing_pkg::TWO_RETRACE] ||
                 panel_timing_pkg::is_stn(panelType) || st_r.actSync[1];
   end

   always_comb begin
      st_nxt = st_r;

      // Two-stage synchronisers for the pin inputs.
      st_nxt.lineSync = {st_r.lineSync[0], inputLineSync};
      st_nxt.frameSync = {st_r.frameSync[0], inputFrameSync};
      st_nxt.actSync = {st_r.actSync[0], dataActive};
      st_nxt.linePrev = lineNorm;
      st_nxt.framePrev = frameNorm;

      // Edge counter restarts at every leading edge and stops at its limit.
      if (lineEdge) begin
         st_nxt.edgeCnt = 5'h01;
         st_nxt.running = 1'b1;
      end else if (st_r.running) begin
         if (st_r.edgeCnt == 5'h1f) begin
            st_nxt.running = 1'b0;
         end else begin
            st_nxt.edgeCnt = st_r.edgeCnt + 5'h01;
         end
      end

      // Output line sync: raw pass or rebuilt pulse.
      st_nxt.lineOut = regen ? (genActive ^ lineInv) : st_r.lineSync[1];

      // Frame marker generation and line counting.
      if (frameEdge) begin
         st_nxt.armed = 1'b1;
         st_nxt.lineCount = '0;
      end else if (lineEdge) begin
         st_nxt.marker = 1'b0;
         if (st_r.armed) begin
            // Marker over the first line after each frame sync.
            st_nxt.marker = 1'b1;
            st_nxt.armed = 1'b0;
         end else if (dual && halfTotal != '0 && st_r.lineCount == halfTotal) begin
            // Second marker once the upper half has been scanned.
            st_nxt.marker = 1'b1;
         end
         if (st_r.lineCount != '1) begin
            st_nxt.lineCount = st_r.lineCount + TOTAL_W'(1);
         end
      end
      st_nxt.markerOut = bypass ? st_r.frameSync[1] : (st_nxt.marker ^ frameInv);

      // Register writes.
      if (regWrite) begin
         if (regAddr == panel_timing_pkg::OFS_TIMING_ONE) begin
            st_nxt.timingOne = regWrData;
         end
         if (regAddr == panel_timing_pkg::OFS_TIMING_TWO) begin
            st_nxt.timingTwo = regWrData;
         end
      end

      // Read data stands for exactly one cycle; unmapped reads return zero.
      st_nxt.rdData = 32'h0000_0000;
      if (regRead) begin
         unique case (regAddr)
            panel_timing_pkg::OFS_TIMING_ONE: st_nxt.rdData = st_r.timingOne;
            panel_timing_pkg::OFS_TIMING_TWO: st_nxt.rdData = st_r.timingTwo;
            panel_timing_pkg::OFS_STATUS: begin
               st_nxt.rdData[panel_timing_pkg::STAT_COUNT_LSB +: TOTAL_W] = st_r.lineCount;
               st_nxt.rdData[panel_timing_pkg::STAT_MARKER] = st_r.marker;
               st_nxt.rdData[panel_timing_pkg::STAT_RUNNING] = st_r.running;
               st_nxt.rdData[panel_timing_pkg::STAT_DUAL] = dual;
            end
            default: st_nxt.rdData = 32'h0000_0000;
         endcase
      end
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         st_r <= '0;
         st_r.timingOne <= panel_timing_pkg::RESET_TIMING_ONE;
         st_r.timingTwo <= panel_timing_pkg::RESET_TIMING_TWO;
      end else begin
         st_r <= st_nxt;
      end
   end

   // Shift clock divider, gated to active data where the panel allows.
   shift_clock_gen shiftDiv (
      .clk(clk),
      .nrst(nrst),
      .panelType(panelType),
      .gateOpen(gateOpen),
      .shiftTick(panelShiftClock)
   );

   assign regRdData = st_r.rdData;
   assign latchPulseOutput = st_r.lineOut;
   assign firstLineMarker = st_r.markerOut;

   default clocking cb @(posedge clk); endclocking
   default disable iff (!nrst);

   sequence lineHeldPass;
      (!regen)[*4];
   endsequence

   sequence frameHeldPass;
      bypass[*4];
   endsequence

   lead_zero_a: assert property (
      lineEdge && regen && !lineInv && leadCode == 3'h0 && trailCode != 5'h00
      |=> latchPulseOutput)
      else $error("Zero leading delay did not start the pulse at once.");

   lead_reached_a: assert property (
      regen && !lineInv && st_r.running && !lineEdge && st_r.edgeCnt == leadDly &&
      trailCode > leadDly |=> latchPulseOutput)
      else $error("Line pulse missing at its leading edge position.");

   lead_early_a: assert property (
      regen && !lineInv && st_r.running && !lineEdge && leadDly >= 5'h02 &&
      st_r.edgeCnt == leadDly - 5'h01 |=> !latchPulseOutput)
      else $error("Line pulse started before its leading edge position.");

   trail_end_a: assert property (
      regen && !lineInv && st_r.running && !lineEdge && st_r.edgeCnt == trailCode
      |=> !latchPulseOutput)
      else $error("Line pulse ran past its trailing edge position.");

   no_pulse_a: assert property (
      regen && !lineInv && trailCode <= leadDly |=> !latchPulseOutput)
      else $error("Line pulse produced for an empty window.");

   line_pass_a: assert property (
      lineHeldPass |-> latchPulseOutput == $past(inputLineSync, 3))
      else $error("Passed line sync differs from the input pin.");

   line_pol_a: assert property (
      regen && lineInv && !st_r.running && !lineEdge |=> latchPulseOutput)
      else $error("Inverted line sync does not idle high.");

   frame_pass_a: assert property (
      frameHeldPass |-> firstLineMarker == $past(inputFrameSync, 3))
      else $error("Bypassed frame sync differs from the input pin.");

   first_marker_a: assert property (
      !bypass && !frameInv && st_r.armed && lineEdge && !frameEdge |=> firstLineMarker)
      else $error("First line marker missing after frame sync.");

   half_marker_a: assert property (
      !bypass && !frameInv && dual && !st_r.armed && lineEdge && !frameEdge &&
      halfTotal != '0 && st_r.lineCount == halfTotal |=> firstLineMarker)
      else $error("Second marker missing at half panel height.");

   frame_inv_a: assert property (
      !bypass && frameInv && !lineEdge && !st_r.marker |=> firstLineMarker)
      else $error("Inverted frame marker does not idle high.");

   read_data_a: assert property (
      regRead && regAddr == panel_timing_pkg::OFS_TIMING_TWO && !regWrite
      |=> regRdData == $past(st_r.timingTwo) ##1 ($past(regRead) || regRdData == 32'h0000_0000))
      else $error("Register read data wrong or held too long.");

   unmapped_read_a: assert property (
      regRead && regAddr != panel_timing_pkg::OFS_TIMING_ONE &&
      regAddr != panel_timing_pkg::OFS_TIMING_TWO && regAddr != panel_timing_pkg::OFS_STATUS
      |=> regRdData == 32'h0000_0000)
      else $error("Unmapped register read returned nonzero data.");

   write_lands_a: assert property (
      regWrite && regAddr == panel_timing_pkg::OFS_TIMING_ONE
      |=> st_r.timingOne == $past(regWrData))
      else $error("Register write did not land.");

   status_ro_a: assert property (
      regWrite && regAddr == panel_timing_pkg::OFS_STATUS
      |=> $stable(st_r.timingOne) && $stable(st_r.timingTwo))
      else $error("Write to the status word changed a timing register.");

   edge_restart_a: assert property (
      lineEdge |=> st_r.running && st_r.edgeCnt == 5'h01)
      else $error("Edge counter did not restart at the line sync edge.");

   count_stop_a: assert property (
      st_r.running && !lineEdge && st_r.edgeCnt == 5'h1f |=> !st_r.running)
      else $error("Edge counter ran past its limit.");

   bypass_line_a: assert property (
      frameHeldPass |-> latchPulseOutput == $past(inputLineSync, 3))
      else $error("Line sync was rebuilt although bypass was set.");

   rebuild_idle_a: assert property (
      regen && !lineInv && !st_r.running && !lineEdge |=> !latchPulseOutput)
      else $error("Rebuilt line sync left its idle level without an edge.");

   pulse_mid_a: assert property (
      regen && !lineInv && st_r.running && !lineEdge && st_r.edgeCnt > leadDly &&
      st_r.edgeCnt < trailCode |=> latchPulseOutput)
      else $error("Line pulse dropped inside its window.");

   frame_arm_a: assert property (
      frameEdge |=> st_r.armed && st_r.lineCount == '0)
      else $error("Frame sync edge did not arm the marker.");

   single_once_a: assert property (
      !bypass && !frameInv && !dual && !st_r.armed && lineEdge && !frameEdge
      |=> !firstLineMarker)
      else $error("Extra first line marker in single scan mode.");

   marker_hold_a: assert property (
      !bypass && !lineEdge && $stable(frameInv) && $stable(bypass)
      |=> $stable(firstLineMarker))
      else $error("Frame marker moved between line edges.");

   gate_shut_a: assert property (
      !bypass && st_r.timingTwo[panel_timing_pkg::TWO_RETRACE] &&
      !panel_timing_pkg::is_stn(panelType) && !st_r.actSync[1] |=> !panelShiftClock)
      else $error("Shift clock ran during retrace.");

   // Five cycles cover the longest shift period, so a stopped STN clock is always caught.
   sequence stnRetrace;
      (st_r.timingTwo[panel_timing_pkg::TWO_RETRACE] && !bypass &&
       panel_timing_pkg::is_stn(panelType))[*5];
   endsequence

   stn_free_a: assert property (
      stnRetrace |-> panelShiftClock || $past(panelShiftClock) || $past(panelShiftClock, 2) ||
                     $past(panelShiftClock, 3))
      else $error("Retrace control stopped the shift clock of an STN panel.");

endmodule : panel_output_sync_timing

`default_nettype wire

// ### core/shift_clock_gen.sv
// Panel shift clock divider running on the pixel clock.
`timescale 1ns/1ps
`default_nettype none

module shift_clock_gen (
   // Clock and reset
   input wire logic clk,
   input wire logic nrst,
   // Control
   input wire logic [3:0] panelType,
   input wire logic gateOpen,
   // Shift clock strobe
   output logic shiftTick
);

   typedef struct packed {
      logic [1:0] cnt;
      logic [1:0] phase;
      logic tick;
   } div_t;

   div_t st_r;
   div_t st_nxt;

   always_comb begin
      logic [2:0] period;
      period = panel_timing_pkg::shift_period(panelType, st_r.phase);
      st_nxt = st_r;
      st_nxt.tick = 1'b0;
      if (!gateOpen) begin
         st_nxt.cnt = 2'h0;
      end else if ({1'b0, st_r.cnt} >= period - 3'h1) begin
         // Greater-or-equal lets a shorter period take over at once after a type change.
         // One shift clock per period; the phase steps through 3,2,3.
         st_nxt.tick = 1'b1;
         st_nxt.cnt = 2'h0;
         st_nxt.phase = (st_r.phase == panel_timing_pkg::PATTERN_LAST) ? 2'h0 :
                        st_r.phase + 2'h1;
      end else begin
         st_nxt.cnt = st_r.cnt + 2'h1;
      end
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign shiftTick = st_r.tick;

   default clocking cb @(posedge clk); endclocking
   default disable iff (!nrst);

   quarter_rate_a: assert property (
      shiftTick && panelType == panel_timing_pkg::TYPE_DSTN24 ##1
      (panelType == panel_timing_pkg::TYPE_DSTN24)[*3]
      |-> !shiftTick && !$past(shiftTick) && !$past(shiftTick, 2) ##1 shiftTick)
      else $error("Shift clock is not a quarter of the pixel clock.");

   full_rate_a: assert property (
      (gateOpen && panelType == panel_timing_pkg::TYPE_TFT9)[*2] |=> shiftTick)
      else $error("Shift clock is not at the full pixel rate.");

   gate_closed_a: assert property (
      !gateOpen |=> !shiftTick)
      else $error("Shift clock ran while gated off.");

endmodule : shift_clock_gen

`default_nettype wire

// ### inc/panel_timing_pkg.sv
// Register map, field layout, panel codes and helper functions for the panel sync timing block.
package panel_timing_pkg;

   // Register port addresses (byte addresses, one word each).
   localparam int ADDR_W = 12;
   localparam logic [11:0] OFS_TIMING_ONE = 12'h400;
   localparam logic [11:0] OFS_TIMING_TWO = 12'h404;
   localparam logic [11:0] OFS_STATUS = 12'h408;
   localparam logic [31:0] RESET_TIMING_ONE = 32'h0000_0000;
   localparam logic [31:0] RESET_TIMING_TWO = 32'h0000_0000;

   // Fields of panel_timing_one.
   localparam int ONE_FRAME_POL = 30;
   localparam int ONE_LINE_POL = 29;
   localparam int ONE_SRC_SEL = 27;
   localparam int ONE_TOTAL_LSB = 16;
   localparam int ONE_TOTAL_W = 11;
   localparam int ONE_LEAD_LSB = 5;
   localparam int ONE_LEAD_W = 3;
   localparam int ONE_TRAIL_LSB = 0;
   localparam int ONE_TRAIL_W = 5;

   // Fields of panel_timing_two.
   localparam int TWO_BYPASS = 30;
   localparam int TWO_RETRACE = 27;
   localparam int TWO_LINE_OVR = 26;
   localparam int TWO_FRAME_OVR = 24;
   localparam int TWO_FRAME_INV = 23;
   localparam int TWO_LINE_POL = 22;
   localparam int TWO_TYPE_LSB = 18;
   localparam int TWO_TYPE_W = 4;

   // Fields of the read-only status word.
   localparam int STAT_COUNT_LSB = 0;
   localparam int STAT_MARKER = 16;
   localparam int STAT_RUNNING = 17;
   localparam int STAT_DUAL = 18;

   // Panel type codes held in panel_timing_two type field.
   localparam logic [3:0] TYPE_DSTN24 = 4'h0;
   localparam logic [3:0] TYPE_DSTN16 = 4'h1;
   localparam logic [3:0] TYPE_SSTN8 = 4'h2;
   localparam logic [3:0] TYPE_TFT9 = 4'h3;
   localparam logic [3:0] TYPE_TFT18 = 4'h4;
   localparam logic [3:0] TYPE_TFT9X2 = 4'h5;
   localparam logic [3:0] TYPE_TFT12X2 = 4'h6;

   // Shift clock periods in pixel clocks.
   localparam logic [2:0] DIV_QUARTER = 3'h4;
   localparam logic [2:0] DIV_HALF = 3'h2;
   localparam logic [2:0] DIV_FULL = 3'h1;
   localparam logic [2:0] DIV_LONG = 3'h3;
   localparam logic [2:0] DIV_SHORT = 3'h2;
   localparam logic [1:0] PATTERN_LAST = 2'h2;

   // Leading edge code 0 means no delay; the others skip a delay of one.
   function automatic logic [4:0] lead_delay(input logic [2:0] code);
      lead_delay = (code == 3'h0) ? 5'h00 : ({2'h0, code} + 5'h01);
   endfunction : lead_delay

   function automatic logic is_dual(input logic [3:0] panelType);
      is_dual = (panelType == TYPE_DSTN24) || (panelType == TYPE_DSTN16);
   endfunction : is_dual

   function automatic logic is_stn(input logic [3:0] panelType);
      is_stn = is_dual(panelType) || (panelType == TYPE_SSTN8);
   endfunction : is_stn

   // Period of the current shift clock cycle; phase walks the 3,2,3 pattern.
   function automatic logic [2:0] shift_period(input logic [3:0] panelType,
                                               input logic [1:0] phase);
      unique case (panelType)
         TYPE_DSTN24: shift_period = DIV_QUARTER;
         TYPE_DSTN16, TYPE_SSTN8: shift_period = (phase == 2'h1) ? DIV_SHORT : DIV_LONG;
         TYPE_TFT9X2, TYPE_TFT12X2: shift_period = DIV_HALF;
         default: shift_period = DIV_FULL;
      endcase
   endfunction : shift_period

endpackage : panel_timing_pkg

// ### test/panel_model.sv
// Panel side model: counts shift clock ticks and first line marker starts at the panel pins.
`timescale 1ns/1ps
`default_nettype none

module panel_model (
   // Clock and control
   input wire logic clk,
   input wire logic clear,
   input wire logic markIdle,
   // Panel pins
   input wire logic marker,
   input wire logic shift,
   // Counts
   output logic [15:0] ticks,
   output logic [15:0] marks
);
   logic prevMark;

   // A start is any move away from the idle level, so both marker polarities count alike.
   always @(posedge clk) begin
      prevMark <= marker;
      if (clear) begin
         ticks <= 16'h0000;
         marks <= 16'h0000;
      end else begin
         ticks <= ticks + {15'h0, shift};
         marks <= marks + {15'h0, (prevMark === markIdle) && (marker === ~markIdle)};
      end
   end
endmodule : panel_model

`default_nettype wire

// ### test/panel_output_sync_timing_tb.sv
// Self-checking bench for the panel output sync timing block.
`timescale 1ns/1ps
`default_nettype none

module panel_output_sync_timing_tb;
   logic clk = 1'b0;
   logic nrst = 1'b0;
   logic [11:0] regAddr = 12'h000;
   logic [31:0] regWrData = 32'h0;
   logic regWrite = 1'b0;
   logic regRead = 1'b0;
   logic [31:0] regRdData;
   logic lineIn = 1'b0;
   logic frameIn = 1'b0;
   logic dataActive = 1'b0;
   logic latchOut;
   logic markOut;
   logic shiftOut;
   logic clear = 1'b0;
   logic markIdle = 1'b0;
   logic [15:0] ticks;
   logic [15:0] marks;
   logic [31:0] rd;
   logic [31:0] rnd;
   int err_count = 0;
   int samples_checked = 0;
   int cycles = 0;

   always #12.5 clk = ~clk;

   panel_output_sync_timing dut (.clk(clk), .nrst(nrst), .regAddr(regAddr),
      .regWrData(regWrData), .regWrite(regWrite), .regRead(regRead), .regRdData(regRdData),
      .inputLineSync(lineIn), .inputFrameSync(frameIn), .dataActive(dataActive),
      .latchPulseOutput(latchOut), .firstLineMarker(markOut), .panelShiftClock(shiftOut));

   panel_model panel (.clk(clk), .clear(clear), .markIdle(markIdle), .marker(markOut),
      .shift(shiftOut), .ticks(ticks), .marks(marks));

   task automatic final_report;
      $display("checks %0d mismatches %0d", samples_checked, err_count);
      if (err_count == 0 && samples_checked > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask : final_report

   // A hung handshake must still end in the closing report.
   always @(posedge clk) begin
      cycles++;
      if (cycles == 20000) begin
         err_count++;
         final_report();
      end
   end

   task automatic cmpWord(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp) begin
         err_count++;
         $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
      end
   endtask : cmpWord

   task automatic cmpCount(input int got, input int exp);
      samples_checked++;
      if (got != exp) begin
         err_count++;
         $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
      end
   endtask : cmpCount

   function automatic logic [31:0] mk1(bit fp, bit lp, bit src, int tot, int ld, int tr);
      return {1'b0, fp, lp, 1'b0, src, tot[10:0], 8'h00, ld[2:0], tr[4:0]};
   endfunction : mk1

   function automatic logic [31:0] mk2(bit byp, bit ret, bit lo, bit fo, bit fi, bit lpol,
                                       int ty);
      return {1'b0, byp, 2'h0, ret, lo, 1'b0, fo, fi, lpol, ty[3:0], 18'h0};
   endfunction : mk2

   function automatic int tickExp(int ty);
      return ty == 0 ? 6 : (ty == 1 || ty == 2) ? 9 : (ty == 5 || ty == 6) ? 12 : 24;
   endfunction : tickExp

   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      @(posedge clk);
      regWrite <= 1'b1;
      regAddr <= a;
      regWrData <= d;
      @(posedge clk);
      regWrite <= 1'b0;
   endtask : wr

   task automatic rdReg(input logic [11:0] a, output logic [31:0] d);
      @(posedge clk);
      regRead <= 1'b1;
      regAddr <= a;
      @(posedge clk);
      regRead <= 1'b0;
      #1 d = regRdData;
   endtask : rdReg

   // The long settle lets any pulse started by a polarity change run out first.
   task automatic cfg(input logic [31:0] o, input logic [31:0] t);
      wr(12'h400, o);
      wr(12'h404, t);
      repeat (40) @(posedge clk);
   endtask : cfg

   task automatic lineRun(input logic idle, input logic outIdle, input int expFirst,
                          input int expCnt);
      int first;
      int cnt;
      first = -1;
      cnt = 0;
      @(posedge clk);
      lineIn <= ~idle;
      for (int k = 1; k <= 40; k++) begin
         @(posedge clk);
         if (k == 4) lineIn <= idle;
         #1;
         if (latchOut !== outIdle) begin
            cnt++;
            if (first < 0) first = k;
         end
      end
      cmpCount(first, expFirst);
      cmpCount(cnt, expCnt);
   endtask : lineRun

   task automatic lineCase(input int ld, input int tr, input bit lp, input bit lo, input bit pol);
      int l;
      l = (ld == 0) ? 0 : ld + 1;
      @(posedge clk);
      lineIn <= lp;
      cfg(mk1(0, lp, 1, 0, ld, tr), mk2(0, 0, lo, 0, 0, pol, 4));
      lineRun(lp, lo & pol, tr > l ? 3 + l : -1, tr > l ? tr - l : 0);
   endtask : lineCase

   task automatic frameRun(input logic [31:0] o, input logic [31:0] t, input logic fIdle,
                           input logic mIdle, input int lines, input int exp);
      @(posedge clk);
      frameIn <= fIdle;
      lineIn <= 1'b0;
      markIdle <= mIdle;
      cfg(o, t);
      clear <= 1'b1;
      @(posedge clk);
      clear <= 1'b0;
      frameIn <= ~fIdle;
      repeat (2) @(posedge clk);
      frameIn <= fIdle;
      repeat (lines) begin
         repeat (9) @(posedge clk);
         lineIn <= 1'b1;
         repeat (3) @(posedge clk);
         lineIn <= 1'b0;
      end
      repeat (16) @(posedge clk);
      #1;
      cmpWord({16'h0000, marks}, exp);
   endtask : frameRun

   task automatic shiftRun(input logic [31:0] t, input logic act, input int exp);
      @(posedge clk);
      dataActive <= act;
      cfg(32'h0, t);
      clear <= 1'b1;
      @(posedge clk);
      clear <= 1'b0;
      repeat (24) @(posedge clk);
      #1;
      cmpWord({16'h0000, ticks}, exp);
   endtask : shiftRun

   initial begin
      rnd = $urandom(38035);
      repeat (6) @(posedge clk);
      nrst <= 1'b1;
      rdReg(12'h400, rd);
      cmpWord(rd, panel_timing_pkg::RESET_TIMING_ONE);
      rdReg(12'h404, rd);
      cmpWord(rd, panel_timing_pkg::RESET_TIMING_TWO);
      rnd = $urandom;
      wr(12'h400, rnd);
      wr(12'h408, ~rnd);
      rdReg(12'h400, rd);
      cmpWord(rd, rnd);
      rdReg(12'h40c, rd);
      cmpWord(rd, 32'h0);
      @(posedge clk);
      nrst <= 1'b0;
      repeat (2) @(posedge clk);
      nrst <= 1'b1;
      rdReg(12'h400, rd);
      cmpWord(rd, panel_timing_pkg::RESET_TIMING_ONE);
      $display("registers done");
      cfg(mk1(0, 0, 0, 0, 3, 20), mk2(0, 0, 1, 0, 0, 1, 4));
      lineRun(0, 0, 3, 4);
      cfg(mk1(0, 0, 1, 0, 3, 20), mk2(1, 0, 1, 0, 0, 1, 4));
      lineRun(0, 0, 3, 4);
      lineCase(0, 0, 0, 0, 0);
      lineCase(1, 1, 0, 0, 0);
      lineCase(1, 2, 0, 0, 0);
      lineCase(0, 1, 1, 0, 0);
      lineCase(7, 31, 0, 1, 1);
      lineCase(0, 28, 0, 0, 1);
      repeat (10) lineCase($urandom % 8, $urandom % 32, $urandom % 2, $urandom % 2,
                           $urandom % 2);
      $display("line sync done");
      frameRun(mk1(0, 0, 0, 0, 0, 0), mk2(0, 0, 0, 0, 0, 0, 2), 0, 0, 9, 1);
      frameRun(mk1(0, 0, 0, 8, 0, 0), mk2(0, 0, 0, 0, 0, 0, 1), 0, 0, 9, 2);
      rdReg(12'h408, rd);
      cmpWord(rd & 32'h0004_07ff, 32'h0004_0009);
      frameRun(mk1(1, 0, 0, 0, 0, 0), mk2(0, 0, 0, 0, 0, 0, 2), 1, 0, 9, 1);
      frameRun(mk1(0, 0, 0, 0, 0, 0), mk2(0, 0, 0, 1, 1, 0, 2), 0, 1, 9, 1);
      frameRun(mk1(0, 0, 0, 0, 0, 0), mk2(0, 0, 0, 0, 1, 0, 2), 0, 0, 9, 1);
      frameRun(mk1(0, 0, 0, 0, 0, 0), mk2(1, 0, 0, 1, 1, 0, 2), 0, 0, 0, 1);
      $display("frame marker done");
      for (int ty = 0; ty < 8; ty++) shiftRun(mk2(0, 0, 0, 0, 0, 0, ty), 1, tickExp(ty));
      shiftRun(mk2(0, 1, 0, 0, 0, 0, 4), 0, 0);
      shiftRun(mk2(0, 1, 0, 0, 0, 0, 4), 1, 24);
      shiftRun(mk2(0, 1, 0, 0, 0, 0, 0), 0, 6);
      shiftRun(mk2(1, 1, 0, 0, 0, 0, 4), 0, 24);
      $display("shift clock done");
      final_report();
   end
endmodule : panel_output_sync_timing_tb

`default_nettype wire
